/* hdl/scs_pkg.sv */
// Package for the system clock source select block.
// Assumes a single 50 MHz APB clock; oscillators arrive as tick enables.
package scs_pkg;
    // APB register byte offsets
    localparam logic [7:0] SCS_OFS_CTRL = 8'h00;   // system_clock_control
    localparam logic [7:0] SCS_OFS_TRIM = 8'h04;   // crystal_load_trim
    localparam logic [7:0] SCS_OFS_RF = 8'h08;     // crystal and radio enables
    localparam logic [7:0] SCS_OFS_STAT = 8'h0c;   // active selection status
    // Field positions in the control and crystal/radio enable registers
    localparam int SCS_POS_FHS = 0;                // high_speed_source_select
    localparam int SCS_POS_SEL = 4;                // sys_clk_select, 3 bits
    localparam int SCS_POS_XEN = 0;                // crystal_osc_enable
    localparam int SCS_POS_RPU = 1;                // radio_power_up
    // Reset values
    localparam logic [2:0] SCS_RST_SEL = 3'h0;     // Fast clock, divide by 1
    localparam logic SCS_RST_FHS = 1'b0;           // Internal fast RC
    localparam logic [7:0] SCS_RST_TRIM = 8'h00;
    // Selection code that picks the low speed clock
    localparam logic [2:0] SCS_SEL_SLOW = 3'h7;
    // Nominal oscillator rates in kHz, informational for the bench
    localparam int SCS_FAST_RC_KHZ = 16000;
    localparam int SCS_SLOW_RC_KHZ = 32;
    // Source enumeration for the high speed clock
    typedef enum logic {
        SCS_SRC_FAST_RC = 1'b0,
        SCS_SRC_CRYSTAL = 1'b1
    } scs_src_t;
    // Active clock setting carried as one unit
    typedef struct packed {
        logic [2:0] sel;
        scs_src_t src;
    } scs_setting_t;
endpackage

/* hdl/scs_top.sv */
// System clock source select: APB registers, source mux, divider, clock enables.
// Assumes oscillator ticks are one-cycle pulses synchronous to pclk.
//
// Overview of operation
// - System vs low speed clock by select field
// - High speed from crystal or fast RC
// - Select field also sets resulting frequency
// - Always one high and one low source
// - Clocks go to radio, watchdog, time base
// - Crystal also clocks the radio circuitry
// - Fast RC fixed, no frequency select
// - Low speed source is internal slow RC
// - Crystal load set from trim register
// - High speed divided by 1 to 64
// - Low speed clock from slow RC
// - Crystal enabled by enable and radio power
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module scs_top (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator ticks
    input wire logic external_crystal_osc,
    input wire logic internal_fast_rc,
    input wire logic internal_slow_rc,
    // Clock enables out
    output logic sys_clk_en,
    output logic high_speed_clock_en,
    output logic low_speed_clock_en,
    output logic radio_clk_en,
    output logic wdt_clk_en,
    output logic timebase_clk_en,
    // Analog controls
    output logic crystal_osc_on,
    output logic [7:0] crystal_load_trim
);
    import scs_pkg::*;

    logic [2:0] sys_clk_select;          // Requested selection
    logic high_speed_source_select;      // Requested high speed source
    logic crystal_osc_enable;            // Crystal enable bit
    logic radio_power_up;                // Radio power bit
    scs_setting_t active;                // Setting in force
    logic [5:0] div_cnt;                 // High speed divider count
    logic hs_tick;                       // Chosen high speed tick
    logic xtal_live;                     // Crystal allowed to run
    logic boundary;                      // System clock pulse this cycle
    logic forced; // Crystal lost under a fast setting
    logic setup;                         // APB setup phase
    logic wr_access;                     // APB write completes

    // Divider limit for a selection code: 2^sel - 1
    function automatic logic [5:0] div_limit(input logic [2:0] sel);
        div_limit = 6'(({6'h00, 1'b1} << sel) - 7'h01);
    endfunction

    // Address decode
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == SCS_OFS_CTRL) || (a == SCS_OFS_TRIM) || (a == SCS_OFS_RF) || (a == SCS_OFS_STAT);
    endfunction

    // APB phase decode
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite && pready;
    assign xtal_live = crystal_osc_enable && radio_power_up;
    // Crystal ticks only pass while enabled; chooses the source
    assign hs_tick = (active.src == SCS_SRC_CRYSTAL) ? (external_crystal_osc && xtal_live) : internal_fast_rc;
    // A pulse ends the current clock period; only here, or on a forced switch, may the setting change
    assign boundary = (active.sel == SCS_SEL_SLOW) ? internal_slow_rc
        : (hs_tick && div_cnt == div_limit(active.sel));
    // A fast crystal setting with the crystal gone never reaches a boundary, so it is left at once
    assign forced = (active.src == SCS_SRC_CRYSTAL) && !xtal_live && (active.sel != SCS_SEL_SLOW);

    // Control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_select <= SCS_RST_SEL;
            high_speed_source_select <= SCS_RST_FHS;
            crystal_load_trim <= SCS_RST_TRIM;
            crystal_osc_enable <= 1'b0;
            radio_power_up <= 1'b0;
        end else if (wr_access) begin
            // Single bit source field: no code leaves a speed without an oscillator
            if (paddr == SCS_OFS_CTRL) begin
                sys_clk_select <= pwdata[SCS_POS_SEL +: 3];
                high_speed_source_select <= pwdata[SCS_POS_FHS];
            end
            if (paddr == SCS_OFS_TRIM) begin
                crystal_load_trim <= pwdata[7:0];
            end
            if (paddr == SCS_OFS_RF) begin
                crystal_osc_enable <= pwdata[SCS_POS_XEN];
                radio_power_up <= pwdata[SCS_POS_RPU];
            end
        end
    end

    // APB answer: one access cycle, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped(paddr);
            if (setup && !pwrite) begin
                unique case (paddr)
                    SCS_OFS_CTRL: prdata <= {24'h00_0000, 1'b0, sys_clk_select, 3'h0, high_speed_source_select};
                    SCS_OFS_TRIM: prdata <= {24'h00_0000, crystal_load_trim};
                    SCS_OFS_RF: prdata <= {30'h0000_0000, radio_power_up, crystal_osc_enable};
                    SCS_OFS_STAT: prdata <= {24'h00_0000, 1'b0, active.sel, 2'h0, xtal_live, active.src};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Adopt a new setting only at a period boundary, or at once when the
    // crystal it runs on is gone and no boundary can ever come
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= '{sel: SCS_RST_SEL, src: SCS_SRC_FAST_RC};
        end else if (boundary || forced) begin
            active <= '{sel: sys_clk_select, src: scs_src_t'(high_speed_source_select)};
        end
    end

    // High speed divider count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 6'h00;
        end else if (boundary || forced || active.sel == SCS_SEL_SLOW) begin
            // A forced switch restarts the count so the new ratio starts clean
            div_cnt <= 6'h00;
        end else if (hs_tick) begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    // Registered clock enables to the system and peripherals
    // Peripheral enables follow the oscillators, the radio one gated by xtal_live, not the selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_en <= 1'b0;
            high_speed_clock_en <= 1'b0;
            low_speed_clock_en <= 1'b0;
            radio_clk_en <= 1'b0;
            wdt_clk_en <= 1'b0;
            timebase_clk_en <= 1'b0;
            crystal_osc_on <= 1'b0;
        end else begin
            sys_clk_en <= boundary;
            high_speed_clock_en <= hs_tick;
            low_speed_clock_en <= internal_slow_rc;
            radio_clk_en <= external_crystal_osc && xtal_live;
            wdt_clk_en <= internal_slow_rc;
            timebase_clk_en <= internal_slow_rc;
            crystal_osc_on <= xtal_live;
        end
    end

    // Checks
    a_slow_tracks_rc: assert property (@(posedge pclk) disable iff (!presetn)
        (active.sel == SCS_SEL_SLOW && internal_slow_rc) |=> sys_clk_en)
        else $error("slow mode missed a slow tick");
    a_slow_no_fast: assert property (@(posedge pclk) disable iff (!presetn)
        (active.sel == SCS_SEL_SLOW && !internal_slow_rc) |=> !sys_clk_en)
        else $error("slow mode pulse without slow tick");
    a_div_bound: assert property (@(posedge pclk) disable iff (!presetn)
        div_cnt <= div_limit(active.sel) || active.sel == SCS_SEL_SLOW)
        else $error("divider count beyond limit");
    a_div_one: assert property (@(posedge pclk) disable iff (!presetn)
        (active.sel == 3'h0 && hs_tick) |=> sys_clk_en)
        else $error("divide by one missed a tick");
    a_switch_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (active != $past(active)) |-> ($past(boundary) || $past(forced))
        ) else $error("setting changed mid period");
    a_xtal_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !(crystal_osc_enable && radio_power_up) |=> !crystal_osc_on && !radio_clk_en)
        else $error("crystal ran while not enabled");
    a_radio_clock: assert property (@(posedge pclk) disable iff (!presetn)
        (external_crystal_osc && xtal_live) |=> radio_clk_en)
        else $error("radio lost a crystal tick");
    a_wdt_clock: assert property (@(posedge pclk) disable iff (!presetn)
        internal_slow_rc |=> (wdt_clk_en && timebase_clk_en && low_speed_clock_en))
        else $error("slow tick not routed");
    a_fast_src: assert property (@(posedge pclk) disable iff (!presetn)
        (active.src == SCS_SRC_FAST_RC) |-> (hs_tick == internal_fast_rc))
        else $error("fast RC not used as source");
    a_trim_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == SCS_OFS_TRIM) |=> crystal_load_trim == $past(pwdata[7:0]))
        else $error("trim not stored");
    // Divider restarts after every period end and every forced switch
    a_div_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (boundary || forced) |=> (div_cnt == 6'h00))
        else $error("divider not restarted after switch");
    // Control writes land in the select field
    a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == SCS_OFS_CTRL) |=> (sys_clk_select == $past(pwdata[SCS_POS_SEL +: 3])))
        else $error("clock select not stored");
    // Radio enable only follows a live crystal tick
    a_radio_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !(external_crystal_osc && xtal_live) |=> !radio_clk_en)
        else $error("radio tick without live crystal");
    // The chosen high speed tick is forwarded one cycle later
    a_hs_route: assert property (@(posedge pclk) disable iff (!presetn)
        hs_tick |=> high_speed_clock_en)
        else $error("high speed tick not forwarded");
    // Slow selection holds the high speed divider at rest
    a_slow_idle_div: assert property (@(posedge pclk) disable iff (!presetn)
        (active.sel == SCS_SEL_SLOW) |=> (div_cnt == 6'h00))
        else $error("divider ran in slow mode");
endmodule

/* verif/tb_system_clock_source_select.sv */
// Testbench for the clock source select block: APB access and tick counting.
// Assumes scs_pkg and scs_top are compiled first; oscillator ticks are driven here.
`timescale 1ns/1ps
module tb_system_clock_source_select;
    import scs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite; // Bus controls
    logic [7:0] paddr; // Byte address
    logic [31:0] pwdata, prdata, rd; // Data, last read
    logic pready, pslverr, err, fr, xt, sr; // Answers and ticks
    logic [5:0] ens; // Watched clock enables
    logic [7:0] trim; // Load trim pin
    logic xon, cnt_on; // Crystal on, counting window
    int cnt [6]; // Pulses seen per enable
    int n_fail, comparisons;
    scs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_crystal_osc(xt), .internal_fast_rc(fr), .internal_slow_rc(sr),
        .sys_clk_en(ens[0]), .high_speed_clock_en(ens[1]), .low_speed_clock_en(ens[2]),
        .radio_clk_en(ens[3]), .wdt_clk_en(ens[4]), .timebase_clk_en(ens[5]),
        .crystal_osc_on(xon), .crystal_load_trim(trim));
    // Free running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Count enable pulses mid-cycle, where outputs are settled
    always @(negedge pclk) begin
        for (int i = 0; i < 6; i++) begin
            if (cnt_on && ens[i] === 1'b1) cnt[i]++;
        end
    end
    // Compare one value, count and report
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Drive n one-cycle ticks; trailing idle lets the last pulse land
    task automatic ticks(input logic f, input logic x, input logic s, input int n);
        repeat (n) begin
            @(posedge pclk);
            fr <= f;
            xt <= x;
            sr <= s;
            @(posedge pclk);
            fr <= 1'b0;
            xt <= 1'b0;
            sr <= 1'b0;
        end
        repeat (3) @(posedge pclk);
    endtask
    // Settle any pending switch, then count pulses over n ticks
    task automatic meas(input logic f, input logic x, input logic s, input int n);
        ticks(f, x, s, 64);
        foreach (cnt[i]) cnt[i] = 0;
        cnt_on = 1'b1;
        ticks(f, x, s, n);
        cnt_on = 1'b0;
    endtask
    // Print the verdict and stop
    task automatic complete_run;
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard, well beyond the expected run
    initial begin
        #200000;
        n_fail++;
        complete_run;
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, fr, xt, sr, cnt_on} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SCS_OFS_CTRL, 32'h0);
        check("ctrl_reset", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, err});
        check("unmapped_rd", 32'h0, rd);
        apb(1'b1, SCS_OFS_TRIM, 32'h000000a5);
        apb(1'b0, SCS_OFS_TRIM, 32'h0);
        check("trim_rd", 32'ha5, rd);
        check("trim_pin", 32'ha5, {24'h0, trim});
        // Crystal runs only with both enable and radio power
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, SCS_OFS_RF, i);
            repeat (2) @(posedge pclk);
            check("xtal_on", (i == 3), {31'h0, xon});
        end
        // Every high speed divide ratio on the fast RC
        for (int n = 0; n < 7; n++) begin
            apb(1'b1, SCS_OFS_CTRL, n << SCS_POS_SEL);
            meas(1'b1, 1'b0, 1'b1, 2 * (1 << n));
            check("sys_div", 32'h2, cnt[0]);
            check("hs_ticks", 2 * (1 << n), cnt[1]);
            check("wdt_ticks", 2 * (1 << n), cnt[4]);
            check("tbase_ticks", 2 * (1 << n), cnt[5]);
        end
        // Slow selection ignores fast ticks and follows the slow RC
        apb(1'b1, SCS_OFS_CTRL, 32'(SCS_SEL_SLOW) << SCS_POS_SEL);
        meas(1'b1, 1'b0, 1'b0, 8);
        check("slow_no_fast", 32'h0, cnt[0]);
        meas(1'b0, 1'b0, 1'b1, 8);
        check("slow_sys", 32'h8, cnt[0]);
        check("slow_ls", 32'h8, cnt[2]);
        // Crystal as high speed source, divide by 2
        apb(1'b1, SCS_OFS_CTRL, (32'h1 << SCS_POS_SEL) | 32'h1);
        meas(1'b0, 1'b1, 1'b1, 8);
        check("xtal_sys", 32'h4, cnt[0]);
        apb(1'b0, SCS_OFS_STAT, 32'h0);
        check("stat_xtal", 32'h13, rd);
        check("xtal_radio", 32'h8, cnt[3]);
        meas(1'b1, 1'b0, 1'b0, 8);
        check("xtal_no_fast", 32'h0, cnt[0]);
        // Disabled crystal feeds nothing
        apb(1'b1, SCS_OFS_RF, 32'h1);
        meas(1'b0, 1'b1, 1'b0, 8);
        check("xtal_off_radio", 32'h0, cnt[3]);
        // Losing the crystal lets a new fast setting take over at once
        apb(1'b1, SCS_OFS_CTRL, 32'h0);
        apb(1'b0, SCS_OFS_STAT, 32'h0);
        check("stat_forced", 32'h0, rd);
        meas(1'b1, 1'b0, 1'b0, 8);
        check("forced_sys", 32'h8, cnt[0]);
        // Reset in mid-run clears the registers again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SCS_OFS_TRIM, 32'h0);
        check("rst_trim", 32'h0, rd);
        check("rst_xtal", 32'h0, {31'h0, xon});
        complete_run;
    end
endmodule
